/* pkg/cfu_pkg.sv */
// Shared constants for the address, scalar and vector control units.
package cfu_pkg;
  localparam int A_W = 24;
  localparam int S_W = 64;
  localparam int VL_W = 7;
  localparam int NVREG = 8;
  localparam int OP_W = 9;
  localparam int CNT_W = 7;
  localparam logic [VL_W-1:0] VL_FULL = 7'h40;
  localparam logic [VL_W-1:0] VL_ZERO = 7'h00;
  localparam logic [S_W-1:0] ONES64 = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [S_W-1:0] ZERO64 = 64'h0000000000000000;
  localparam logic [7:0] DSH_LIMIT = 8'h80;
  localparam logic [A_W-1:0] CIRC_LIMIT = 24'h000040;
  localparam logic [2:0] REG_ZERO = 3'h0;
  // Opcodes, written in hex; the names give the function, not the value.
  localparam logic [OP_W-1:0] OP_VM_LOAD = 9'h003;
  localparam logic [OP_W-1:0] OP_VL_LOAD = 9'h002;
  localparam logic [OP_W-1:0] OP_POP = 9'h016;
  localparam logic [OP_W-1:0] OP_LZC = 9'h017;
  localparam logic [OP_W-1:0] OP_AADD = 9'h018;
  localparam logic [OP_W-1:0] OP_ASUB = 9'h019;
  localparam logic [OP_W-1:0] OP_AMUL = 9'h01A;
  localparam logic [OP_W-1:0] OP_LMASKL = 9'h022;
  localparam logic [OP_W-1:0] OP_LMASKR = 9'h023;
  localparam logic [OP_W-1:0] OP_LAND = 9'h024;
  localparam logic [OP_W-1:0] OP_LANDN = 9'h025;
  localparam logic [OP_W-1:0] OP_LXOR = 9'h026;
  localparam logic [OP_W-1:0] OP_LXNOR = 9'h027;
  localparam logic [OP_W-1:0] OP_LMERGE = 9'h028;
  localparam logic [OP_W-1:0] OP_LOR = 9'h029;
  localparam logic [OP_W-1:0] OP_SHL0 = 9'h02A;
  localparam logic [OP_W-1:0] OP_SHR0 = 9'h02B;
  localparam logic [OP_W-1:0] OP_SHL = 9'h02C;
  localparam logic [OP_W-1:0] OP_SHR = 9'h02D;
  localparam logic [OP_W-1:0] OP_DSHL = 9'h02E;
  localparam logic [OP_W-1:0] OP_DSHR = 9'h02F;
  localparam logic [OP_W-1:0] OP_SADD = 9'h030;
  localparam logic [OP_W-1:0] OP_SSUB = 9'h031;
  // Unit times in clock periods.
  localparam int LAT_AADD = 2;
  localparam int LAT_AMUL = 4;
  localparam int LAT_SADD = 3;
  localparam int LAT_SSH1 = 2;
  localparam int LAT_SSH2 = 3;
  localparam int LAT_SLOG = 1;
  localparam int LAT_POP = 4;
  localparam int LAT_LZC = 3;
endpackage

/* pkg/cfu_pipe_if.sv */
// Carrier between the unit front end and a fixed-latency result pipe.
`timescale 1ns/1ps
`default_nettype none
interface cfu_pipe_if #(parameter int W = 64);
  logic in_valid;
  logic [W-1:0] in_data;
  logic out_valid;
  logic [W-1:0] out_data;
  modport src (output in_valid, output in_data, input out_valid, input out_data);
  modport pipe (input in_valid, input in_data, output out_valid, output out_data);
endinterface
`default_nettype wire

/* hdl/cfu_pipe.sv */
// Fixed-latency, fully segmented result pipe.
`timescale 1ns/1ps
`default_nettype none
module cfu_pipe #(
  parameter int W = 64,
  parameter int D = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  cfu_pipe_if.pipe p
);
  typedef struct packed {
    logic [D-1:0] vld;
    logic [D-1:0][W-1:0] dat;
  } cfu_pstate_t;
  cfu_pstate_t st_reg;
  cfu_pstate_t st_next;

  // Every stage moves each cycle, so a new operand set enters each period.
  always_comb begin
    st_next = st_reg;
    st_next.vld[0] = p.in_valid;
    st_next.dat[0] = p.in_data;
    for (int n = 1; n < D; n++) begin
      st_next.vld[n] = st_reg.vld[n-1];
      st_next.dat[n] = st_reg.dat[n-1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign p.out_valid = st_reg.vld[D-1];
  assign p.out_data = st_reg.dat[D-1];
endmodule // cfu_pipe
`default_nettype wire

/* hdl/cfu_units.sv */
// Address and scalar units, vector length and mask, vector register reservations.
// Function
// - An operand-reserved vector register is refused as source or destination until released.
// - One vector instruction may name one register as source and destination.
// - A register feeds one operation and receives from one operation at once.
// - Each vector issue latches its own length and scalar; neither register is reserved.
// - Base and stride address registers of vector memory ops are never reserved.
// - Length register is seven bits; written zero means a length of 64.
// - Length steers opcodes 140-177, loaded by 0020, read back by 023301.
// - Mask has 64 bits; top bit is element 0, bottom bit element 63.
// - Mask loaded by 003, made by 175, selects merges, read by 073.
// - Every unit finishes in a constant time with no stalls.
// - Every unit accepts a new operand set each clock.
// - All units here operate concurrently.
// - Address add and subtract, 24 bits, subtract by complement plus one.
// - Address add result appears two clocks after entry.
// - Address multiply keeps the low 24 product bits, no overflow.
// - Address multiply result appears four clocks after entry.
// - Scalar 64-bit add and subtract, no overflow, three clocks.
// - Single and double end-off shifts; double turns circular for equal nonzero designators and counts up to 64.
// - Single shifts take two clocks, double shifts three clocks.
// - Scalar logical operations 042-051 take one clock.
// - Population count of 64 bits in four clocks, 7-bit address result.
// - Leading zero count in three clocks, result to an address register.
`timescale 1ns/1ps
`default_nettype none
module cfu_units
  import cfu_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic i_ISS_VALID,
  input wire logic [OP_W-1:0] i_ISS_OPCODE,
  input wire logic [2:0] i_ISS_I,
  input wire logic [2:0] i_ISS_J,
  input wire logic [2:0] i_ISS_K,
  input wire logic [A_W-1:0] i_ISS_AJ,
  input wire logic [A_W-1:0] i_ISS_AK,
  input wire logic [S_W-1:0] i_ISS_SI,
  input wire logic [S_W-1:0] i_ISS_SJ,
  input wire logic [S_W-1:0] i_ISS_SK,
  input wire logic i_VTEST_VALID,
  input wire logic [S_W-1:0] i_VTEST_MASK,
  input wire logic [5:0] i_MERGE_ELEM,
  input wire logic i_VEC_VALID,
  input wire logic [2:0] i_VEC_DST,
  input wire logic [2:0] i_VEC_SRC1,
  input wire logic [2:0] i_VEC_SRC2,
  input wire logic i_VEC_USE_DST,
  input wire logic i_VEC_USE_SRC1,
  input wire logic i_VEC_USE_SRC2,
  input wire logic [S_W-1:0] i_VEC_SCALAR,
  input wire logic [NVREG-1:0] i_VREL_OPND,
  input wire logic [NVREG-1:0] i_VREL_RES,
  output logic o_VEC_GRANT,
  output logic o_VEC_STB,
  output logic [CNT_W-1:0] o_VEC_LEN,
  output logic [S_W-1:0] o_VEC_SCALAR,
  output logic [NVREG-1:0] o_OPND_RES,
  output logic [NVREG-1:0] o_RES_RES,
  output logic [VL_W-1:0] o_VL_READ,
  output logic [CNT_W-1:0] o_VL_EFF,
  output logic [S_W-1:0] o_VM_READ,
  output logic o_MERGE_SEL,
  output logic o_AADD_VALID,
  output logic [A_W-1:0] o_AADD_DATA,
  output logic o_AMUL_VALID,
  output logic [A_W-1:0] o_AMUL_DATA,
  output logic o_SADD_VALID,
  output logic [S_W-1:0] o_SADD_DATA,
  output logic o_SSH1_VALID,
  output logic [S_W-1:0] o_SSH1_DATA,
  output logic o_SSH2_VALID,
  output logic [S_W-1:0] o_SSH2_DATA,
  output logic o_SLOG_VALID,
  output logic [S_W-1:0] o_SLOG_DATA,
  output logic o_POP_VALID,
  output logic [CNT_W-1:0] o_POP_DATA,
  output logic o_LZC_VALID,
  output logic [CNT_W-1:0] o_LZC_DATA
);
  typedef struct packed {
    logic [VL_W-1:0] vl;
    logic [S_W-1:0] vm;
    logic [NVREG-1:0] opnd_res;
    logic [NVREG-1:0] res_res;
    logic [CNT_W-1:0] vlen;
    logic [S_W-1:0] vsc;
    logic vstb;
  } cfu_state_t;
  cfu_state_t st_reg;
  cfu_state_t st_next;

  cfu_pipe_if #(.W(A_W)) aadd_if ();
  cfu_pipe_if #(.W(A_W)) amul_if ();
  cfu_pipe_if #(.W(S_W)) sadd_if ();
  cfu_pipe_if #(.W(S_W)) ssh1_if ();
  cfu_pipe_if #(.W(S_W)) ssh2_if ();
  cfu_pipe_if #(.W(S_W)) slog_if ();
  cfu_pipe_if #(.W(CNT_W)) pop_if ();
  cfu_pipe_if #(.W(CNT_W)) lzc_if ();

  logic [CNT_W-1:0] vl_eff;
  logic [5:0] jk;
  logic [2*S_W-1:0] dword;
  logic [2*S_W-1:0] dshift;
  logic dcirc;
  logic [CNT_W-1:0] lz;
  logic vec_ok;
  logic [NVREG-1:0] set_opnd;
  logic [NVREG-1:0] set_res;

  assign vl_eff = (st_reg.vl == VL_ZERO) ? VL_FULL : st_reg.vl;
  assign jk = {i_ISS_J, i_ISS_K};

  // Operands of the double shift; equal nonzero designators with a count up to 64 wrap the register on itself.
  assign dcirc = (i_ISS_I == i_ISS_J) && (i_ISS_I != REG_ZERO) &&
      (i_ISS_AK <= CIRC_LIMIT);
  always_comb begin
    if (i_ISS_OPCODE == OP_DSHL) begin
      dword = {i_ISS_SI, dcirc ? i_ISS_SI : i_ISS_SJ};
      dshift = dword << i_ISS_AK[6:0];
    end else begin
      dword = {dcirc ? i_ISS_SI : i_ISS_SJ, i_ISS_SI};
      dshift = dword >> i_ISS_AK[6:0];
    end
  end

  always_comb begin
    lz = VL_FULL;
    for (int n = 0; n < S_W; n++) begin
      if (i_ISS_SJ[n]) begin
        lz = CNT_W'(S_W - 1 - n);
      end
    end
  end

  // Each unit decodes on its own, so several units run at once from successive issues.
  always_comb begin
    aadd_if.in_valid = i_ISS_VALID && (i_ISS_OPCODE == OP_AADD || i_ISS_OPCODE == OP_ASUB);
    aadd_if.in_data = (i_ISS_OPCODE == OP_ASUB) ?
        A_W'(i_ISS_AJ + ~i_ISS_AK + 1'b1) : A_W'(i_ISS_AJ + i_ISS_AK);
    amul_if.in_valid = i_ISS_VALID && (i_ISS_OPCODE == OP_AMUL);
    amul_if.in_data = A_W'(i_ISS_AJ * i_ISS_AK);
    sadd_if.in_valid = i_ISS_VALID && (i_ISS_OPCODE == OP_SADD || i_ISS_OPCODE == OP_SSUB);
    sadd_if.in_data = (i_ISS_OPCODE == OP_SSUB) ?
        S_W'(i_ISS_SJ + ~i_ISS_SK + 1'b1) : S_W'(i_ISS_SJ + i_ISS_SK);
    ssh1_if.in_valid = i_ISS_VALID && (i_ISS_OPCODE >= OP_SHL0) && (i_ISS_OPCODE <= OP_SHR);
    ssh1_if.in_data = i_ISS_OPCODE[0] ? (i_ISS_SI >> jk) : (i_ISS_SI << jk);
    ssh2_if.in_valid = i_ISS_VALID && (i_ISS_OPCODE == OP_DSHL || i_ISS_OPCODE == OP_DSHR);
    if ({16'h0000, i_ISS_AK} >= {32'(DSH_LIMIT)}) begin
      ssh2_if.in_data = ZERO64;
    end else if (i_ISS_OPCODE == OP_DSHL) begin
      ssh2_if.in_data = dshift[2*S_W-1:S_W];
    end else begin
      ssh2_if.in_data = dshift[S_W-1:0];
    end
    slog_if.in_valid = i_ISS_VALID && (i_ISS_OPCODE >= OP_LMASKL) && (i_ISS_OPCODE <= OP_LOR);
    case (i_ISS_OPCODE)
      OP_LMASKL: slog_if.in_data = ~(ONES64 >> jk);
      OP_LMASKR: slog_if.in_data = ~(ONES64 << jk);
      OP_LAND: slog_if.in_data = i_ISS_SJ & i_ISS_SK;
      OP_LANDN: slog_if.in_data = i_ISS_SK & ~i_ISS_SJ;
      OP_LXOR: slog_if.in_data = i_ISS_SJ ^ i_ISS_SK;
      OP_LXNOR: slog_if.in_data = ~(i_ISS_SJ ^ i_ISS_SK);
      OP_LMERGE: slog_if.in_data = (i_ISS_SJ & i_ISS_SK) | (i_ISS_SI & ~i_ISS_SK);
      OP_LOR: slog_if.in_data = i_ISS_SJ | i_ISS_SK;
      default: slog_if.in_data = ZERO64;
    endcase
    pop_if.in_valid = i_ISS_VALID && (i_ISS_OPCODE == OP_POP);
    pop_if.in_data = CNT_W'($countones(i_ISS_SJ));
    lzc_if.in_valid = i_ISS_VALID && (i_ISS_OPCODE == OP_LZC);
    lzc_if.in_data = lz;
  end

  // Fixed-depth pipes: no stall input exists, so timing never varies.
  cfu_pipe #(.W(A_W), .D(LAT_AADD)) u_aadd (
    .i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .p(aadd_if));
  cfu_pipe #(.W(A_W), .D(LAT_AMUL)) u_amul (
    .i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .p(amul_if));
  cfu_pipe #(.W(S_W), .D(LAT_SADD)) u_sadd (
    .i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .p(sadd_if));
  cfu_pipe #(.W(S_W), .D(LAT_SSH1)) u_ssh1 (
    .i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .p(ssh1_if));
  cfu_pipe #(.W(S_W), .D(LAT_SSH2)) u_ssh2 (
    .i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .p(ssh2_if));
  cfu_pipe #(.W(S_W), .D(LAT_SLOG)) u_slog (
    .i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .p(slog_if));
  cfu_pipe #(.W(CNT_W), .D(LAT_POP)) u_pop (
    .i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .p(pop_if));
  cfu_pipe #(.W(CNT_W), .D(LAT_LZC)) u_lzc (
    .i_clk(I_CORE_CLK), .i_rst(I_SYS_RST), .p(lzc_if));

  // A result-reserved source is still accepted, which is what lets chaining start.
  always_comb begin
    vec_ok = 1'b1;
    if (i_VEC_USE_SRC1 && st_reg.opnd_res[i_VEC_SRC1]) vec_ok = 1'b0;
    if (i_VEC_USE_SRC2 && st_reg.opnd_res[i_VEC_SRC2]) vec_ok = 1'b0;
    if (i_VEC_USE_DST && (st_reg.opnd_res[i_VEC_DST] || st_reg.res_res[i_VEC_DST])) begin
      vec_ok = 1'b0;
    end
    set_opnd = '0;
    set_res = '0;
    if (i_VEC_VALID && vec_ok) begin
      // The destination's own source reservation is placed only now, so it never blocks itself.
      if (i_VEC_USE_SRC1) set_opnd[i_VEC_SRC1] = 1'b1;
      if (i_VEC_USE_SRC2) set_opnd[i_VEC_SRC2] = 1'b1;
      if (i_VEC_USE_DST) set_res[i_VEC_DST] = 1'b1;
    end
  end

  always_comb begin
    st_next = st_reg;
    if (i_ISS_VALID && i_ISS_OPCODE == OP_VL_LOAD) begin
      st_next.vl = i_ISS_AK[VL_W-1:0];
    end
    if (i_VTEST_VALID) begin
      st_next.vm = i_VTEST_MASK;
    end else if (i_ISS_VALID && i_ISS_OPCODE == OP_VM_LOAD) begin
      st_next.vm = i_ISS_SJ;
    end
    // A new reservation wins over a release arriving in the same cycle.
    st_next.opnd_res = (st_reg.opnd_res & ~i_VREL_OPND) | set_opnd;
    st_next.res_res = (st_reg.res_res & ~i_VREL_RES) | set_res;
    st_next.vstb = i_VEC_VALID && vec_ok;
    if (i_VEC_VALID && vec_ok) begin
      st_next.vlen = vl_eff;
      st_next.vsc = i_VEC_SCALAR;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Address operands of vector memory ops never enter this state, so they stay free.
  assign o_VEC_GRANT = i_VEC_VALID && vec_ok;
  assign o_VEC_STB = st_reg.vstb;
  assign o_VEC_LEN = st_reg.vlen;
  assign o_VEC_SCALAR = st_reg.vsc;
  assign o_OPND_RES = st_reg.opnd_res;
  assign o_RES_RES = st_reg.res_res;
  assign o_VL_READ = st_reg.vl;
  assign o_VL_EFF = vl_eff;
  assign o_VM_READ = st_reg.vm;
  assign o_MERGE_SEL = st_reg.vm[S_W-1-i_MERGE_ELEM];
  assign o_AADD_VALID = aadd_if.out_valid;
  assign o_AADD_DATA = aadd_if.out_data;
  assign o_AMUL_VALID = amul_if.out_valid;
  assign o_AMUL_DATA = amul_if.out_data;
  assign o_SADD_VALID = sadd_if.out_valid;
  assign o_SADD_DATA = sadd_if.out_data;
  assign o_SSH1_VALID = ssh1_if.out_valid;
  assign o_SSH1_DATA = ssh1_if.out_data;
  assign o_SSH2_VALID = ssh2_if.out_valid;
  assign o_SSH2_DATA = ssh2_if.out_data;
  assign o_SLOG_VALID = slog_if.out_valid;
  assign o_SLOG_DATA = slog_if.out_data;
  assign o_POP_VALID = pop_if.out_valid;
  assign o_POP_DATA = pop_if.out_data;
  assign o_LZC_VALID = lzc_if.out_valid;
  assign o_LZC_DATA = lzc_if.out_data;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);

  wire iss_aadd = i_ISS_VALID && i_ISS_OPCODE == OP_AADD;
  wire iss_asub = i_ISS_VALID && i_ISS_OPCODE == OP_ASUB;

  aadd_time_a: assert property (iss_aadd |-> ##2 (o_AADD_VALID &&
      o_AADD_DATA == A_W'($past(i_ISS_AJ, 2) + $past(i_ISS_AK, 2))))
    else $error("Address add result wrong or late.");
  asub_value_a: assert property (iss_asub |-> ##2
      (o_AADD_DATA == A_W'($past(i_ISS_AJ, 2) - $past(i_ISS_AK, 2))))
    else $error("Address subtract result wrong.");
  amul_time_a: assert property ((i_ISS_VALID && i_ISS_OPCODE == OP_AMUL) |->
      ##4 (o_AMUL_VALID && o_AMUL_DATA == A_W'($past(i_ISS_AJ, 4) *
      $past(i_ISS_AK, 4))))
    else $error("Address multiply result wrong or late.");
  sadd_time_a: assert property (sadd_if.in_valid |-> ##3 o_SADD_VALID)
    else $error("Scalar add result late.");
  shift_time_a: assert property (ssh2_if.in_valid |-> ##3 o_SSH2_VALID)
    else $error("Double shift result late.");
  logic_time_a: assert property (slog_if.in_valid |=> o_SLOG_VALID)
    else $error("Logical result late.");
  pop_count_a: assert property (pop_if.in_valid |-> ##4
      (o_POP_VALID && o_POP_DATA == CNT_W'($countones($past(i_ISS_SJ, 4)))))
    else $error("Population count wrong or late.");
  lzc_zero_a: assert property ((lzc_if.in_valid && i_ISS_SJ == ZERO64) |-> ##3
      (o_LZC_VALID && o_LZC_DATA == VL_FULL))
    else $error("Leading zero count of zero operand wrong.");
  vl_zero_a: assert property ((o_VL_READ == VL_ZERO) |-> (o_VL_EFF == VL_FULL))
    else $error("Zero length not taken as full length.");
  opnd_block_a: assert property ((i_VEC_VALID && i_VEC_USE_SRC1 &&
      o_OPND_RES[i_VEC_SRC1]) |-> !o_VEC_GRANT)
    else $error("Issue granted on operand-reserved source.");
  len_latch_a: assert property (o_VEC_GRANT |=>
      (o_VEC_STB && o_VEC_LEN == $past(vl_eff)))
    else $error("Vector length copy not latched.");
  vm_load_a: assert property ((i_ISS_VALID && i_ISS_OPCODE == OP_VM_LOAD &&
      !i_VTEST_VALID) |=> (o_VM_READ == $past(i_ISS_SJ)))
    else $error("Mask load lost.");

  chain_issue_c: cover property (o_VEC_GRANT && i_VEC_USE_SRC1 && o_RES_RES[i_VEC_SRC1]);
  recur_issue_c: cover property (o_VEC_GRANT && i_VEC_USE_DST && i_VEC_SRC1 == i_VEC_DST);
  back_to_back_c: cover property (iss_aadd ##1 iss_asub ##1 o_AADD_VALID ##1 o_AADD_VALID);
  circ_shift_c: cover property (ssh2_if.in_valid && dcirc);
endmodule // cfu_units
`default_nettype wire

/* test/cfu_vrel_model.sv */
// Model of the vector units that hand reservations back after a fixed time.
`timescale 1ns/1ps
`default_nettype none
module cfu_vrel_model
  import cfu_pkg::*;
#(
  parameter int HOLD = 30
) (
  input wire logic i_clk,
  input wire logic i_grant,
  input wire logic [NVREG-1:0] i_opnd,
  input wire logic [NVREG-1:0] i_res,
  output logic [NVREG-1:0] o_rel_opnd,
  output logic [NVREG-1:0] o_rel_res
);
  logic [NVREG-1:0] opnd_q [HOLD];
  logic [NVREG-1:0] res_q [HOLD];
  // Each granted operation hands back its registers exactly HOLD clocks later.
  always @(posedge i_clk) begin
    for (int n = 0; n < HOLD - 1; n++) begin
      opnd_q[n] <= opnd_q[n + 1];
      res_q[n] <= res_q[n + 1];
    end
    opnd_q[HOLD-1] <= i_grant ? i_opnd : 8'h00;
    res_q[HOLD-1] <= i_grant ? i_res : 8'h00;
  end
  // Release pulses stay low until the pipe has filled, so none is invented at start.
  assign o_rel_opnd = (opnd_q[0] === 8'hXX) ? 8'h00 : opnd_q[0];
  assign o_rel_res = (res_q[0] === 8'hXX) ? 8'h00 : res_q[0];
endmodule // cfu_vrel_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the address, scalar and vector control units.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cfu_pkg::*;
();
  logic clk, rst, iss_v, vt_v, vv, ud, us1, us2, g, stb, msel;
  logic aav, amv, sav, s1v, s2v, slv, pv, lv;
  logic [OP_W-1:0] op;
  logic [2:0] di, dj, dk, vd, vs1, vs2;
  logic [A_W-1:0] aj, ak, aad, amd;
  logic [S_W-1:0] si, sj, sk, vt_m, vsc, vsco, vmr, sad, s1d, s2d, sld;
  logic [5:0] m_el;
  logic [NVREG-1:0] rel_o, rel_r, ores, rres, om, rm;
  logic [CNT_W-1:0] vlen, vle, pd, ld;
  logic [VL_W-1:0] vlr;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  assign om = ({NVREG{us1}} & (8'h01 << vs1)) | ({NVREG{us2}} & (8'h01 << vs2));
  assign rm = {NVREG{ud}} & (8'h01 << vd);
  cfu_units u_cfu_units (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .i_ISS_VALID(iss_v), .i_ISS_OPCODE(op),
    .i_ISS_I(di), .i_ISS_J(dj), .i_ISS_K(dk), .i_ISS_AJ(aj), .i_ISS_AK(ak),
    .i_ISS_SI(si), .i_ISS_SJ(sj), .i_ISS_SK(sk), .i_VTEST_VALID(vt_v), .i_VTEST_MASK(vt_m),
    .i_MERGE_ELEM(m_el), .i_VEC_VALID(vv), .i_VEC_DST(vd), .i_VEC_SRC1(vs1),
    .i_VEC_SRC2(vs2), .i_VEC_USE_DST(ud), .i_VEC_USE_SRC1(us1), .i_VEC_USE_SRC2(us2),
    .i_VEC_SCALAR(vsc), .i_VREL_OPND(rel_o), .i_VREL_RES(rel_r), .o_VEC_GRANT(g),
    .o_VEC_STB(stb), .o_VEC_LEN(vlen), .o_VEC_SCALAR(vsco), .o_OPND_RES(ores),
    .o_RES_RES(rres), .o_VL_READ(vlr), .o_VL_EFF(vle), .o_VM_READ(vmr), .o_MERGE_SEL(msel),
    .o_AADD_VALID(aav), .o_AADD_DATA(aad), .o_AMUL_VALID(amv), .o_AMUL_DATA(amd),
    .o_SADD_VALID(sav), .o_SADD_DATA(sad), .o_SSH1_VALID(s1v), .o_SSH1_DATA(s1d),
    .o_SSH2_VALID(s2v), .o_SSH2_DATA(s2d), .o_SLOG_VALID(slv), .o_SLOG_DATA(sld),
    .o_POP_VALID(pv), .o_POP_DATA(pd), .o_LZC_VALID(lv), .o_LZC_DATA(ld)
  );
  cfu_vrel_model #(.HOLD(30)) u_cfu_vrel_model (
    .i_clk(clk), .i_grant(g), .i_opnd(om), .i_res(rm), .o_rel_opnd(rel_o), .o_rel_res(rel_r)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [S_W-1:0] got, input logic [S_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, err_count);
  endtask
  task automatic iss(input logic [OP_W-1:0] o, input logic [A_W-1:0] a, b,
                     input logic [S_W-1:0] x);
    @(negedge clk);
    op = o;
    aj = a;
    ak = b;
    sj = x;
    iss_v = 1'b1;
    @(negedge clk);
    iss_v = 1'b0;
  endtask
  task automatic unit_out(input logic [OP_W-1:0] o, output logic v, output logic [S_W-1:0] d);
    case (o)
      OP_AADD, OP_ASUB: {v, d} = {aav, 40'h0000000000, aad};
      OP_AMUL: {v, d} = {amv, 40'h0000000000, amd};
      OP_SADD, OP_SSUB: {v, d} = {sav, sad};
      OP_SHL0, OP_SHR0: {v, d} = {s1v, s1d};
      OP_DSHL, OP_DSHR: {v, d} = {s2v, s2d};
      OP_POP: {v, d} = {pv, 57'h0, pd};
      OP_LZC: {v, d} = {lv, 57'h0, ld};
      default: {v, d} = {slv, sld};
    endcase
  endtask
  // Result must be absent before its fixed time and present exactly then.
  task automatic sop(input logic [OP_W-1:0] o, input logic [8:0] ijk, input logic [A_W-1:0] a, b,
                     input logic [S_W-1:0] xi, xj, xk, input int lat, input logic [S_W-1:0] e);
    logic v;
    logic [S_W-1:0] d;
    {di, dj, dk} = ijk;
    si = xi;
    sk = xk;
    iss(o, a, b, xj);
    for (int n = 1; n < lat; n++) begin
      unit_out(o, v, d);
      chk(v, 1'b0);
      @(negedge clk);
    end
    unit_out(o, v, d);
    chk(v, 1'b1);
    chk(d, e);
  endtask
  task automatic vop(input logic [2:0] d, s1, input logic [2:0] use3, input logic eg);
    @(negedge clk);
    vd = d;
    vs1 = s1;
    {ud, us1, us2} = use3;
    vv = 1'b1;
    #1;
    chk(g, eg);
    @(negedge clk);
    vv = 1'b0;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    rst = 1'b1;
    {iss_v, vt_v, vv, ud, us1, us2} = 6'h00;
    {op, di, dj, dk, vd, vs1, vs2} = '0;
    {aj, ak, si, sj, sk, vt_m, vsc, m_el} = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    sop(OP_AADD, 9'h000, 24'hFFFFFF, 24'h000002, ZERO64, ZERO64, ZERO64, 2, 64'h1);
    sop(OP_ASUB, 9'h000, 24'h000005, 24'h000007, ZERO64, ZERO64, ZERO64, 2, 64'hFFFFFE);
    sop(OP_AMUL, 9'h000, 24'h001000, 24'h001001, ZERO64, ZERO64, ZERO64, 4, 64'h1000);
    sop(OP_SADD, 9'h000, 24'h000000, 24'h000000, ZERO64, ONES64, 64'h1, 3, ZERO64);
    sop(OP_SSUB, 9'h000, 24'h000000, 24'h000000, ZERO64, 64'h3, 64'h5, 3, ~64'h1);
    sop(OP_SHL0, 9'h004, 24'h000000, 24'h000000, 64'h1, ZERO64, ZERO64, 2, 64'h10);
    sop(OP_SHR0, 9'h03F, 24'h0, 24'h0, ~(ONES64 >> 1), ZERO64, ZERO64, 2, 64'h1);
    sop(OP_DSHL, 9'h050, 24'h0, 24'h000001, 64'h1, ~(ONES64 >> 1), ZERO64, 3, 64'h3);
    sop(OP_DSHL, 9'h0D8, 24'h0, 24'h4, 64'h8000000000000001, ZERO64, ZERO64, 3, 64'h18);
    sop(OP_DSHL, 9'h050, 24'h000000, 24'h000080, ONES64, ONES64, ZERO64, 3, ZERO64);
    sop(OP_DSHR, 9'h050, 24'h0, 24'h4, 64'h10, 64'h1, ZERO64, 3, 64'h1000000000000001);
    sop(OP_LMERGE, 9'h000, 24'h0, 24'h0, ONES64, ZERO64, ONES64 >> 32, 1, ONES64 << 32);
    sop(OP_LMASKL, 9'h004, 24'h0, 24'h0, ZERO64, ZERO64, ZERO64, 1, ONES64 << 60);
    sop(OP_POP, 9'h000, 24'h000000, 24'h000000, ZERO64, ONES64, ZERO64, 4, 64'h40);
    sop(OP_LZC, 9'h000, 24'h0, 24'h0, ZERO64, 64'h0001000000000000, ZERO64, 3, 64'hF);
    sop(OP_LZC, 9'h000, 24'h000000, 24'h000000, ZERO64, ZERO64, ZERO64, 3, 64'h40);
    done("units");
    // Overlapping issues: a unit that stalled or took one set at a time would slip here.
    @(negedge clk);
    op = OP_AADD;
    aj = 24'h000001;
    ak = 24'h000002;
    iss_v = 1'b1;
    @(negedge clk);
    op = OP_ASUB;
    aj = 24'h000010;
    @(negedge clk);
    chk(aad, 24'h000003);
    op = OP_AMUL;
    aj = 24'h000003;
    ak = 24'h000005;
    @(negedge clk);
    chk(aad, 24'h00000E);
    chk(aav, 1'b1);
    iss_v = 1'b0;
    repeat (3) @(negedge clk);
    chk(amd, 24'h00000F);
    chk(amv, 1'b1);
    done("pipeline");
    iss(OP_VL_LOAD, 24'h000000, 24'h000000, ZERO64);
    chk(vlr, 7'h00);
    chk(vle, 7'h40);
    iss(OP_VL_LOAD, 24'h000000, 24'h000005, ZERO64);
    chk(vlr, 7'h05);
    vsc = 64'h00000000000000AB;
    vop(3'h2, 3'h1, 3'h6, 1'b1);
    chk(stb, 1'b1);
    chk(vlen, 7'h05);
    chk(ores, 8'h02);
    chk(rres, 8'h04);
    vsc = 64'h00000000000000CD;
    iss(OP_VL_LOAD, 24'h000000, 24'h000000, ZERO64);
    chk(vsco, 64'hAB);
    vop(3'h4, 3'h3, 3'h6, 1'b1);
    chk(vlen, 7'h40);
    chk(vsco, 64'hCD);
    vop(3'h6, 3'h1, 3'h6, 1'b0);
    vop(3'h1, 3'h7, 3'h6, 1'b0);
    vop(3'h2, 3'h7, 3'h6, 1'b0);
    vop(3'h5, 3'h2, 3'h6, 1'b1);
    vop(3'h7, 3'h7, 3'h6, 1'b1);
    chk(ores, 8'h8E);
    chk(rres, 8'hB4);
    vs2 = 3'h1;
    vop(3'h0, 3'h0, 3'h7, 1'b0);
    for (int n = 0; n < 40 && ores[1] !== 1'b0; n++) @(negedge clk);
    vop(3'h6, 3'h1, 3'h6, 1'b1);
    done("vector issue");
    iss(OP_VM_LOAD, 24'h000000, 24'h000000, 64'h8000000000000001);
    chk(vmr, 64'h8000000000000001);
    m_el = 6'h00;
    #1;
    chk(msel, 1'b1);
    @(negedge clk);
    m_el = 6'h01;
    #1;
    chk(msel, 1'b0);
    @(negedge clk);
    m_el = 6'h3F;
    #1;
    chk(msel, 1'b1);
    @(negedge clk);
    vt_m = 64'h4000000000000000;
    vt_v = 1'b1;
    @(negedge clk);
    vt_v = 1'b0;
    m_el = 6'h01;
    #1;
    chk(msel, 1'b1);
    chk(vmr, 64'h4000000000000000);
    done("mask");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
